// *** logic/od_map.svh ***
// Object indexes, sub-indexes, field positions and reset contents
`ifndef OD_MAP_SVH
`define OD_MAP_SVH

`define OD_IDX_IDENTITY    16'h1018
`define OD_IDX_DIAG        16'h10F3
`define OD_IDX_FREE_FIRST  16'h1600
`define OD_IDX_FREE_LAST   16'h1604
`define OD_IDX_VEL_MAP     16'h1700
`define OD_IDX_VEND_MAP    16'h1701

`define OD_SUB_COUNT       8'h00
`define OD_SUB_ENTRY1      8'h01
`define OD_SUB_ENTRY2      8'h02
`define OD_SUB_REVISION    8'h03
`define OD_SUB_SERIAL      8'h04
`define OD_SUB_FLAGS       8'h05
`define OD_SUB_SLOT_FIRST  8'h06
`define OD_SUB_SLOT_LAST   8'h0D

`define OD_IDENT_ENTRIES   8'h04
`define OD_SERIAL_RST      32'h0000_0000
`define OD_REV_MINOR_MSB   15
`define OD_REV_MAJOR_LSB   16

`define OD_DIAG_ENTRIES    8'h0D
`define OD_DIAG_MAX_RST    4'h0
`define OD_DIAG_MAX        4'h8
`define OD_DIAG_FLAGS_RST  16'h0001
`define OD_DIAG_FLAGS_MAX  32'h0000_0001
`define OD_EMCY_BIT        0
`define OD_CODE_TYPE       16'hE800
`define OD_ERR_FLAG_MASK   16'h0006

`define OD_MAP_LEN_MSB     7
`define OD_MAP_LEN_LIMIT   9'h020
`define OD_FREE_COUNT_RST  8'h00
`define OD_FREE_ENTRY_RST  32'h0000_0000
`define OD_FREE_COUNT_MAX  32'h0000_0002
`define OD_FIXED_COUNT     8'h02
`define OD_VEL_ENTRY1      32'h6040_0010
`define OD_VEL_ENTRY2      32'h6042_0010
`define OD_VEND_ENTRY1     32'h5000_0010
`define OD_VEND_ENTRY2     32'h5010_0010

`endif

// *** logic/od_pkg.sv ***
// Types shared by the object dictionary block
`default_nettype none
package od_pkg;
  typedef enum logic [2:0] {
    ST_OK        = 3'h0,
    ST_NO_OBJECT = 3'h1,
    ST_NO_SUB    = 3'h2,
    ST_READ_ONLY = 3'h3,
    ST_RANGE     = 3'h4,
    ST_MAP_LEN   = 3'h5
  } od_status_t;
endpackage : od_pkg
`default_nettype wire

// *** logic/diag_slot.sv ***
// One diagnosis history record, kept across logic resets
`default_nettype none
module diag_slot (
  input  wire logic        mclk,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_code,
  input  wire logic [15:0] wr_flags,
  input  wire logic [2:0]  sel_word,
  output logic      [31:0] rd_word
);
  logic [31:0] code;
  logic [15:0] flags;

  // No reset: the record must outlive a reset of the logic
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      code  <= wr_code;
      flags <= wr_flags;
    end
  end

  // Word 0 code, word 1 flag word, words 2 to 7 read zero
  assign rd_word = (sel_word == 3'h0) ? code :
                   (sel_word == 3'h1) ? {16'h0000, flags} :
                   32'h0000_0000;
endmodule : diag_slot
`default_nettype wire

// *** logic/od_bank.sv ***
// Object dictionary: identity, diagnosis history and PDO mapping
`include "od_map.svh"
`default_nettype none
module od_bank #(
  // Arbitrary identification values
  parameter logic [31:0] VENDOR_ID  = 32'h0000_0A5A,
  parameter logic [31:0] PRODUCT_ID = 32'h0000_0C3C,
  parameter logic [15:0] REV_MAJOR  = 16'h0001,
  parameter logic [15:0] REV_MINOR  = 16'h0000,
  parameter int          FREE_MAPS  = 5,
  parameter int          SLOTS      = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [15:0]       req_index,
  input  wire logic [7:0]        req_sub,
  input  wire logic [2:0]        req_word,
  input  wire logic [31:0]       req_wdata,
  input  wire logic              diag_valid,
  input  wire logic [15:0]       diag_code,
  input  wire logic [15:0]       diag_kind,
  output logic                   rsp_valid,
  output logic [31:0]            rsp_rdata,
  output od_pkg::od_status_t     rsp_status,
  output logic                   emcy_valid,
  output logic [31:0]            emcy_code,
  output logic [15:0]            emcy_flags,
  output logic                   nv_wr,
  output logic [2:0]             nv_slot,
  output logic [31:0]            nv_code,
  output logic [15:0]            nv_flags
);

  //////////////////////////////////////////////////////////////////////
  // State

  logic [3:0]  diag_max_messages;
  logic [2:0]  wr_ptr;
  logic [2:0]  newest_ptr;
  logic [15:0] diag_notify_flags;
  logic [7:0]  free_rx_map_count     [FREE_MAPS];
  logic [31:0] free_rx_map_entry_one [FREE_MAPS];
  logic [31:0] free_rx_map_entry_two [FREE_MAPS];

  //////////////////////////////////////////////////////////////////////
  // Object decode

  wire logic is_ident = (req_index == `OD_IDX_IDENTITY);
  wire logic is_diag  = (req_index == `OD_IDX_DIAG);
  wire logic is_free  = (req_index >= `OD_IDX_FREE_FIRST) &&
                        (req_index <= `OD_IDX_FREE_LAST);
  wire logic is_vel   = (req_index == `OD_IDX_VEL_MAP);
  wire logic is_vend  = (req_index == `OD_IDX_VEND_MAP);
  wire logic obj_ok   = is_ident || is_diag || is_free || is_vel || is_vend;

  // Low offset bits pick a map only once the index range has matched
  wire logic [15:0] free_off = req_index - `OD_IDX_FREE_FIRST;
  wire logic [2:0]  fi       = free_off[2:0];

  wire logic is_slot = (req_sub >= `OD_SUB_SLOT_FIRST) &&
                       (req_sub <= `OD_SUB_SLOT_LAST);
  wire logic [7:0] slot_off = req_sub - `OD_SUB_SLOT_FIRST;
  wire logic [2:0] slot_sel = slot_off[2:0];

  wire logic sub_map  = (req_sub <= `OD_SUB_ENTRY2);
  wire logic sub_ok   =
    is_ident ? (req_sub <= `OD_SUB_SERIAL) :
    is_diag  ? (req_sub <= `OD_SUB_ENTRY2) ||
               (req_sub == `OD_SUB_FLAGS) || is_slot :
    sub_map;

  //////////////////////////////////////////////////////////////////////
  // Identity object

  wire logic [31:0] rev_word = {REV_MAJOR, REV_MINOR};

  // Read-only identifiers, serial left at default
  wire logic [31:0] ident_word =
    (req_sub == `OD_SUB_COUNT)    ? {24'h00_0000, `OD_IDENT_ENTRIES} :
    (req_sub == `OD_SUB_ENTRY1)   ? VENDOR_ID :
    (req_sub == `OD_SUB_ENTRY2)   ? PRODUCT_ID :
    (req_sub == `OD_SUB_REVISION) ? rev_word :
    `OD_SERIAL_RST;

  //////////////////////////////////////////////////////////////////////
  // Diagnosis history

  // A slot never written since power-up reads unknown: no restore path
  logic [31:0] slot_rd [SLOTS];

  // Profile code above the code-type constant
  wire logic [31:0] new_code  = {diag_code, `OD_CODE_TYPE};
  // Only warning and error bits kept
  wire logic [15:0] new_flags = diag_kind & `OD_ERR_FLAG_MASK;

  // One record per slot, read a word at a time
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      diag_slot u_slot (
        .mclk     (mclk),
        .wr_en    (diag_valid && (wr_ptr == 3'(g))),
        .wr_code  (new_code),
        .wr_flags (new_flags),
        .sel_word (req_word),
        .rd_word  (slot_rd[g])
      );
    end
  endgenerate

  // Newest sub-index is slot pointer plus first slot sub-index
  wire logic [7:0] diag_newest_slot =
    `OD_SUB_SLOT_FIRST + {5'h00, newest_ptr};

  // Count, newest, flags and eight slots in one object
  wire logic [31:0] diag_word =
    (req_sub == `OD_SUB_COUNT)  ? {24'h00_0000, `OD_DIAG_ENTRIES} :
    (req_sub == `OD_SUB_ENTRY1) ? {28'h000_0000, diag_max_messages} :
    (req_sub == `OD_SUB_ENTRY2) ? {24'h00_0000, diag_newest_slot} :
    (req_sub == `OD_SUB_FLAGS)  ? {16'h0000, diag_notify_flags} :
    slot_rd[slot_sel];

  //////////////////////////////////////////////////////////////////////
  // Mapping objects

  // Length field of each free entry
  wire logic [7:0] len1 = free_rx_map_entry_one[fi][`OD_MAP_LEN_MSB:0];
  wire logic [7:0] len2 = free_rx_map_entry_two[fi][`OD_MAP_LEN_MSB:0];
  wire logic [7:0] wlen = req_wdata[`OD_MAP_LEN_MSB:0];

  // Entry one and two each name one object
  wire logic [31:0] free_word =
    (req_sub == `OD_SUB_COUNT)  ? {24'h00_0000, free_rx_map_count[fi]} :
    (req_sub == `OD_SUB_ENTRY1) ? free_rx_map_entry_one[fi] :
    free_rx_map_entry_two[fi];

  // Fixed maps are constants: nothing to write and nothing to reset
  // Control word then target velocity
  wire logic [31:0] vel_word =
    (req_sub == `OD_SUB_COUNT)  ? {24'h00_0000, `OD_FIXED_COUNT} :
    (req_sub == `OD_SUB_ENTRY1) ? `OD_VEL_ENTRY1 :
    `OD_VEL_ENTRY2;

  wire logic [31:0] vend_word =
    (req_sub == `OD_SUB_COUNT)  ? {24'h00_0000, `OD_FIXED_COUNT} :
    (req_sub == `OD_SUB_ENTRY1) ? `OD_VEND_ENTRY1 :
    `OD_VEND_ENTRY2;

  wire logic [31:0] rd_word =
    is_ident ? ident_word :
    is_diag  ? diag_word  :
    is_free  ? free_word  :
    is_vel   ? vel_word   :
    vend_word;

  //////////////////////////////////////////////////////////////////////
  // Write checks

  // Sum of the entries that a new count would bring into use
  wire logic [8:0] cnt_len =
    (req_wdata == 32'h0000_0000) ? 9'h000 :
    (req_wdata == 32'h0000_0001) ? {1'b0, len1} :
    {1'b0, len1} + {1'b0, len2};

  // Checked against the partner entry whatever the count, so a
  // mapping can never be staged past the limit and enabled later
  wire logic [8:0] ent_len =
    (req_sub == `OD_SUB_ENTRY1) ? {1'b0, wlen} + {1'b0, len2} :
    {1'b0, len1} + {1'b0, wlen};

  wire logic flags_wr = is_diag && (req_sub == `OD_SUB_FLAGS);

  wire od_pkg::od_status_t wr_status =
    (flags_wr && req_wdata > `OD_DIAG_FLAGS_MAX) ? od_pkg::ST_RANGE :
    flags_wr ? od_pkg::ST_OK :
    !is_free ? od_pkg::ST_READ_ONLY :
    (req_sub == `OD_SUB_COUNT && req_wdata > `OD_FREE_COUNT_MAX) ?
      od_pkg::ST_RANGE :
    (req_sub == `OD_SUB_COUNT && cnt_len > `OD_MAP_LEN_LIMIT) ?
      od_pkg::ST_MAP_LEN :
    (req_sub != `OD_SUB_COUNT && ent_len > `OD_MAP_LEN_LIMIT) ?
      od_pkg::ST_MAP_LEN :
    od_pkg::ST_OK;

  wire od_pkg::od_status_t status =
    !obj_ok   ? od_pkg::ST_NO_OBJECT :
    !sub_ok   ? od_pkg::ST_NO_SUB :
    req_write ? wr_status :
    od_pkg::ST_OK;

  wire logic wr_go = req_valid && req_write && (status == od_pkg::ST_OK);
  wire logic free_wr = wr_go && is_free;

  //////////////////////////////////////////////////////////////////////
  // Answer

  // Status follows the port every cycle; only the answer cycle counts
  wire logic [31:0] next_rdata =
    (req_valid && !req_write && (status == od_pkg::ST_OK)) ?
      rd_word : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid  <= 1'b0;
      rsp_rdata  <= 32'h0000_0000;
      rsp_status <= od_pkg::ST_OK;
    end else begin
      rsp_valid  <= req_valid;
      rsp_status <= status;
      rsp_rdata  <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Emergency flags

  // Larger values are refused rather than cut down to the low bit
  // Enabled again on every reset of the logic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_notify_flags <= `OD_DIAG_FLAGS_RST;
    end else if (wr_go && flags_wr) begin
      diag_notify_flags <= req_wdata[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // History pointers

  wire logic [3:0] next_count =
    (diag_max_messages == `OD_DIAG_MAX) ?
      diag_max_messages : diag_max_messages + 4'h1;

  // The pointer wraps by its own width, so the slot count stays eight
  // Ascending slots, natural wrap after the eighth
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_max_messages <= `OD_DIAG_MAX_RST;
      wr_ptr            <= 3'h0;
      newest_ptr        <= 3'h0;
    end else if (diag_valid) begin
      diag_max_messages <= next_count;
      newest_ptr        <= wr_ptr;
      wr_ptr            <= wr_ptr + 3'h1;
    end
  end

  // Each stored record also goes out to nonvolatile storage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nv_wr    <= 1'b0;
      nv_slot  <= 3'h0;
      nv_code  <= 32'h0000_0000;
      nv_flags <= 16'h0000;
    end else begin
      nv_wr    <= diag_valid;
      if (diag_valid) begin
        nv_slot  <= wr_ptr;
        nv_code  <= new_code;
        nv_flags <= new_flags;
      end
    end
  end

  // An event meeting a flags write still sees the old flag value
  wire logic next_emcy = diag_valid && diag_notify_flags[`OD_EMCY_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      emcy_valid <= 1'b0;
      emcy_code  <= 32'h0000_0000;
      emcy_flags <= 16'h0000;
    end else begin
      emcy_valid <= next_emcy;
      if (diag_valid) begin
        emcy_code  <= new_code;
        emcy_flags <= new_flags;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Free receive mappings

  // Writable count and entries, zero after reset
  generate
    for (g = 0; g < FREE_MAPS; g++) begin : g_free
      wire logic hit       = free_wr && (fi == 3'(g));
      wire logic load_cnt  = hit && (req_sub == `OD_SUB_COUNT);
      wire logic load_ent1 = hit && (req_sub == `OD_SUB_ENTRY1);
      wire logic load_ent2 = hit && (req_sub == `OD_SUB_ENTRY2);

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          free_rx_map_count[g] <= `OD_FREE_COUNT_RST;
        end else if (load_cnt) begin
          free_rx_map_count[g] <= req_wdata[7:0];
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          free_rx_map_entry_one[g] <= `OD_FREE_ENTRY_RST;
        end else if (load_ent1) begin
          free_rx_map_entry_one[g] <= req_wdata;
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          free_rx_map_entry_two[g] <= `OD_FREE_ENTRY_RST;
        end else if (load_ent2) begin
          free_rx_map_entry_two[g] <= req_wdata;
        end
      end
    end
  endgenerate

endmodule : od_bank
`default_nettype wire

// *** bench/od_bank_checker.sv ***
// Timing and content assertions on the object dictionary ports
`default_nettype none
module od_bank_checker (
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic               req_valid,
  input wire logic               req_write,
  input wire logic [15:0]        req_index,
  input wire logic [7:0]         req_sub,
  input wire logic               diag_valid,
  input wire logic [15:0]        diag_code,
  input wire logic [15:0]        diag_kind,
  input wire logic               rsp_valid,
  input wire logic [31:0]        rsp_rdata,
  input wire od_pkg::od_status_t rsp_status,
  input wire logic               emcy_valid,
  input wire logic               nv_wr,
  input wire logic [2:0]         nv_slot,
  input wire logic [31:0]        nv_code,
  input wire logic [15:0]        nv_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last_slot;
  logic       seen;
  // The first store since reset must use slot 0, each later one the next slot
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_slot <= 3'h0;
      seen      <= 1'b0;
    end else if (nv_wr) begin
      last_slot <= nv_slot;
      seen      <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rsp;
    req_valid |=> rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("answer missing");
  property p_vel;
    req_valid && !req_write && req_index == 16'h1700 && req_sub == 8'h01
      |=> rsp_rdata == 32'h6040_0010 && rsp_status == od_pkg::ST_OK;
  endproperty
  a_vel: assert property (p_vel) else $error("velocity entry");
  property p_ro;
    req_valid && req_write && req_index[15:1] == 15'h0B80 &&
      req_sub <= 8'h02 |=> rsp_status == od_pkg::ST_READ_ONLY;
  endproperty
  a_ro: assert property (p_ro) else $error("fixed map written");
  property p_nv;
    diag_valid |=> nv_wr;
  endproperty
  a_nv: assert property (p_nv) else $error("record not stored");
  property p_code;
    diag_valid |=> nv_code == {$past(diag_code), 16'hE800};
  endproperty
  a_code: assert property (p_code) else $error("code layout");
  property p_flags;
    diag_valid |=> nv_flags == ($past(diag_kind) & 16'h0006);
  endproperty
  a_flags: assert property (p_flags) else $error("flag word");
  property p_slot;
    nv_wr |-> nv_slot == (seen ? 3'(last_slot + 3'h1) : 3'h0);
  endproperty
  a_slot: assert property (p_slot) else $error("slot order");
  property p_emcy;
    emcy_valid |-> $past(diag_valid);
  endproperty
  a_emcy: assert property (p_emcy) else $error("stray emergency");
endmodule : od_bank_checker
bind od_bank od_bank_checker chk (.mclk(mclk), .rst_n(rst_n),
  .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
  .req_sub(req_sub), .diag_valid(diag_valid), .diag_code(diag_code),
  .diag_kind(diag_kind), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
  .rsp_status(rsp_status), .emcy_valid(emcy_valid), .nv_wr(nv_wr),
  .nv_slot(nv_slot), .nv_code(nv_code), .nv_flags(nv_flags));
`default_nettype wire

// *** bench/od_master.sv ***
// Mailbox master model issuing single object accesses
`default_nettype none
module od_master (
  input  wire logic               mclk,
  input  wire logic               rsp_valid,
  input  wire logic [31:0]        rsp_rdata,
  input  wire od_pkg::od_status_t rsp_status,
  output logic                    req_valid,
  output logic                    req_write,
  output logic [15:0]             req_index,
  output logic [7:0]              req_sub,
  output logic [2:0]              req_word,
  output logic [31:0]             req_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {req_valid, req_write, req_index, req_sub, req_word, req_wdata} = '0;
  end
  // one access per call, entry words as given by the caller
  task automatic access(input logic wr, input logic [15:0] idx,
      input logic [7:0] sub, input logic [2:0] wd, input logic [31:0] wv,
      output logic [31:0] rd, output logic [2:0] st, output logic ok);
    int n;
    @(posedge mclk);
    #1;
    {req_write, req_index, req_sub, req_word, req_wdata} =
      {wr, idx, sub, wd, wv};
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    // Released index and data lines show garbage so stale values cannot pass
    req_valid = 1'b0;
    req_wdata = ~wv;
    req_index = ~idx;
    ok = 1'b0;
    for (n = 0; n < 3 && !ok; n++) begin
      if (rsp_valid === 1'b1) ok = 1'b1;
      else @(posedge mclk) #1;
    end
    rd = rsp_rdata;
    st = rsp_status;
  endtask : access
endmodule : od_master
`default_nettype wire

// *** bench/drive_object_dictionary_diag_pdo_map_bench.sv ***
// Self-checking bench for the object dictionary block
`default_nettype none
module drive_object_dictionary_diag_pdo_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identification values
  localparam logic [31:0] VID = 32'h0000_1357;
  localparam logic [31:0] PID = 32'h0000_2468;
  localparam logic [2:0] S_OK = od_pkg::ST_OK;
  logic mclk = 1'b0, rst_n, req_valid, req_write, diag_valid;
  logic rsp_valid, emcy_valid, nv_wr;
  logic [15:0] req_index, diag_code, diag_kind, emcy_flags, nv_flags;
  logic [7:0] req_sub;
  logic [2:0] req_word, nv_slot;
  logic [31:0] req_wdata, rsp_rdata, emcy_code, nv_code;
  od_pkg::od_status_t rsp_status;
  int fail_count = 0, checked = 0, i;
  always #20 mclk = ~mclk;
  od_bank #(.VENDOR_ID(VID), .PRODUCT_ID(PID), .REV_MAJOR(16'h0003),
    .REV_MINOR(16'h0002)) dut (.mclk(mclk), .rst_n(rst_n),
    .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
    .req_sub(req_sub), .req_word(req_word), .req_wdata(req_wdata),
    .diag_valid(diag_valid), .diag_code(diag_code), .diag_kind(diag_kind),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_status(rsp_status),
    .emcy_valid(emcy_valid), .emcy_code(emcy_code),
    .emcy_flags(emcy_flags), .nv_wr(nv_wr), .nv_slot(nv_slot),
    .nv_code(nv_code), .nv_flags(nv_flags));
  od_master master (.mclk(mclk), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_status(rsp_status),
    .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
    .req_sub(req_sub), .req_word(req_word), .req_wdata(req_wdata));
  ////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic xs(input logic wr, input logic [15:0] idx,
      input logic [7:0] sub, input logic [2:0] wd, input logic [31:0] wv,
      input logic [2:0] est, input logic [31:0] erd);
    logic [31:0] rd;
    logic [2:0] st;
    logic ok;
    master.access(wr, idx, sub, wd, wv, rd, st, ok);
    check(32'(ok), 32'h1);
    if (ok !== 1'b1) report_and_stop;
    check(32'(st), 32'(est));
    check(rd, erd);
  endtask : xs
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] e);
    xs(1'b0, idx, sub, 3'h0, 32'h0, S_OK, e);
  endtask : rd
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] v, input od_pkg::od_status_t s);
    xs(1'b1, idx, sub, 3'h0, v, s, 32'h0);
  endtask : wr
  task automatic ev(input logic [15:0] code, input logic [15:0] kind,
      input logic emcy, input logic [2:0] slot);
    @(posedge mclk);
    #1;
    {diag_valid, diag_code, diag_kind} = {1'b1, code, kind};
    @(posedge mclk);
    #1;
    diag_valid = 1'b0;
    check(32'(nv_wr), 32'h1);
    check(32'(nv_slot), 32'(slot));
    check(nv_code, {code, 16'hE800});
    check(32'(nv_flags), 32'(kind & 16'h0006));
    check(32'(emcy_valid), 32'(emcy));
    check(emcy_code, {code, 16'hE800});
    check(32'(emcy_flags), 32'(kind & 16'h0006));
  endtask : ev
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    report_and_stop;
  end
  initial begin
    {rst_n, diag_valid, diag_code, diag_kind} = '0;
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    rd(16'h1018, 8'h00, 32'h4);
    rd(16'h1018, 8'h01, VID);
    rd(16'h1018, 8'h02, PID);
    rd(16'h1018, 8'h03, 32'h0003_0002);
    rd(16'h1018, 8'h04, 32'h0);
    rd(16'h10F3, 8'h00, 32'hD);
    rd(16'h10F3, 8'h01, 32'h0);
    rd(16'h10F3, 8'h02, 32'h6);
    rd(16'h10F3, 8'h05, 32'h1);
    rd(16'h1700, 8'h00, 32'h2);
    rd(16'h1700, 8'h02, 32'h6042_0010);
    rd(16'h1701, 8'h01, 32'h5000_0010);
    rd(16'h1701, 8'h02, 32'h5010_0010);
    rd(16'h1604, 8'h00, 32'h0);
    wr(16'h1700, 8'h01, 32'h0, od_pkg::ST_READ_ONLY);
    rd(16'h1700, 8'h01, 32'h6040_0010);
    wr(16'h1018, 8'h03, 32'h0, od_pkg::ST_READ_ONLY);
    wr(16'h2000, 8'h00, 32'h0, od_pkg::ST_NO_OBJECT);
    xs(1'b0, 16'h1700, 8'h03, 3'h0, 32'h0, od_pkg::ST_NO_SUB, 32'h0);
    wr(16'h10F3, 8'h05, 32'h2, od_pkg::ST_RANGE);
    wr(16'h1600, 8'h01, 32'h6040_0010, od_pkg::ST_OK);
    wr(16'h1600, 8'h02, 32'h6042_0020, od_pkg::ST_MAP_LEN);
    wr(16'h1600, 8'h02, 32'h6042_0010, od_pkg::ST_OK);
    wr(16'h1600, 8'h00, 32'h2, od_pkg::ST_OK);
    wr(16'h1600, 8'h00, 32'h3, od_pkg::ST_RANGE);
    rd(16'h1600, 8'h02, 32'h6042_0010);
    // Nine events: the last must land back in the first slot
    for (i = 0; i < 9; i++) begin
      ev(16'(16'h1000 + i), 16'hFFFF, 1'b1, i[2:0]);
      rd(16'h10F3, 8'h01, (i < 8) ? 32'(i + 1) : 32'h8);
      rd(16'h10F3, 8'h02, 32'(6 + i % 8));
    end
    rd(16'h10F3, 8'h06, 32'h1008_E800);
    xs(1'b0, 16'h10F3, 8'h06, 3'h1, 32'h0, S_OK, 32'h6);
    xs(1'b0, 16'h10F3, 8'h0D, 3'h2, 32'h0, S_OK, 32'h0);
    wr(16'h10F3, 8'h06, 32'h0, od_pkg::ST_READ_ONLY);
    wr(16'h10F3, 8'h05, 32'h0, od_pkg::ST_OK);
    ev(16'h2222, 16'h0002, 1'b0, 3'h1);
    @(posedge mclk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    rd(16'h10F3, 8'h05, 32'h1);
    rd(16'h1600, 8'h00, 32'h0);
    rd(16'h10F3, 8'h07, 32'h2222_E800);
    ev(16'h3333, 16'h0004, 1'b1, 3'h0);
    report_and_stop;
  end
endmodule : drive_object_dictionary_diag_pdo_map_bench
`default_nettype wire
